/* File: verilog/csf_defines.vh */
// constants for the cpu status flag low byte block
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH
// ==========================================================
// register byte offsets on the avalon slave
`define CSF_OFS_STATUS 8'h00
`define CSF_OFS_CORE_CTRL 8'h04
`define CSF_OFS_INT_CTRL1 8'h08
`define CSF_OFS_IRQ_STAT 8'h0c
`define CSF_OFS_IRQ_MASK 8'h10
`define CSF_OFS_EFF_PRIO 8'h14
// ==========================================================
// cpu_status_word field positions
`define CSF_B_C 0
`define CSF_B_Z 1
`define CSF_B_OVF 2
`define CSF_B_N 3
`define CSF_B_RPT 4
`define CSF_B_PRIO_LO 5
`define CSF_B_PRIO_HI 7
`define CSF_B_SAT_ANY 8
`define CSF_B_SAT_B 10
`define CSF_B_SAT_A 11
// core_control_register and interrupt_control_one bits
`define CSF_B_PRIO_MSB 3
`define CSF_B_NEST_DIS 15
// effective priority register bits
`define CSF_B_BLOCKED 4
// ==========================================================
// interrupt status / mask bits
`define CSF_IRQ_OVF 0
`define CSF_IRQ_C 1
`define CSF_IRQ_SAT 2
`define CSF_IRQ_RPT 3
`define CSF_IRQ_W 4
// ==========================================================
// reset values and codes
`define CSF_PRIO_RST 3'h0
`define CSF_PRIO_TOP 3'h7
`define CSF_IRQ_RST 4'h0
`define CSF_OP_ADD 1'b0
`define CSF_OP_SUB 1'b1
`endif

/* File: verilog/csf_flag_calc.v */
// alu adder with negative, overflow, zero and carry flag outputs
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_flag_calc #(
  parameter WIDTH = 16
) (
  // operands and operation
  input wire [WIDTH-1:0] i_op_a,
  input wire [WIDTH-1:0] i_op_b,
  input wire i_op_sub,
  // result and flags
  output wire [WIDTH-1:0] o_result,
  output wire o_neg,
  output wire o_ovf,
  output wire o_zero,
  output wire o_carry
);
  // operand b inverted for subtract; carry-in of one finishes two's complement
  wire [WIDTH-1:0] b_eff;
  wire [WIDTH:0] sum;
  assign b_eff = i_op_sub ? ~i_op_b : i_op_b;
  assign sum = {1'b0, i_op_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, i_op_sub};
  assign o_result = sum[WIDTH-1:0];
  // carry out of the msb; on subtract a one means no borrow
  assign o_carry = sum[WIDTH];
  assign o_neg = sum[WIDTH-1];
  assign o_zero = (sum[WIDTH-1:0] == {WIDTH{1'b0}});
  // sign wrongly changed: like-signed effective operands, unlike result
  assign o_ovf = (i_op_a[WIDTH-1] == b_eff[WIDTH-1]) && (sum[WIDTH-1] != i_op_a[WIDTH-1]);
endmodule // csf_flag_calc

/* File: verilog/csf_status_core.v */
// cpu status word low byte with avalon register access and interrupt
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_status_core #(
  parameter WIDTH = 16,
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // avalon-mm slave
  input wire [ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // alu operation and per-flag update enables
  input wire i_alu_valid,
  input wire [WIDTH-1:0] i_alu_a,
  input wire [WIDTH-1:0] i_alu_b,
  input wire i_alu_sub,
  input wire i_upd_n,
  input wire i_upd_ovf,
  input wire i_upd_z,
  input wire i_upd_c,
  input wire i_z_sticky,
  // repeat loop and accumulator hardware
  input wire i_repeat_active,
  input wire i_sat_a_set,
  input wire i_sat_b_set,
  // interrupt logic priority load
  input wire i_prio_load,
  input wire [3:0] i_prio_value,
  // core outputs
  output reg [WIDTH-1:0] o_alu_result,
  output reg [WIDTH-1:0] o_status_word,
  output reg [3:0] o_eff_priority,
  output reg o_user_irq_blocked,
  output reg o_irq
);
  // ==========================================================
  // flag calculator
  wire [WIDTH-1:0] calc_result;
  wire calc_n;
  wire calc_ovf;
  wire calc_z;
  wire calc_c;

  csf_flag_calc #(
    .WIDTH(WIDTH)
  ) u_calc (
    .i_op_a(i_alu_a),
    .i_op_b(i_alu_b),
    .i_op_sub(i_alu_sub),
    .o_result(calc_result),
    .o_neg(calc_n),
    .o_ovf(calc_ovf),
    .o_zero(calc_z),
    .o_carry(calc_c)
  );

  // ==========================================================
  // state registers
  reg [2:0] lvl_reg; // current priority level field
  reg [2:0] lvl_next;
  reg lvl_msb_reg; // priority_level_msb in core control
  reg lvl_msb_next;
  reg nest_dis_reg; // nesting_disable in interrupt_control_one
  reg nest_dis_next;
  reg rpt_reg; // repeat_active_flag
  reg n_reg; // negative flag
  reg n_next;
  reg ovf_reg; // overflow_flag
  reg ovf_next;
  reg z_reg; // zero flag
  reg z_next;
  reg c_reg; // carry/borrow flag
  reg c_next;
  reg sat_a_reg; // accum_a_saturation_flag
  reg sat_a_next;
  reg sat_b_reg; // accum_b_saturation_flag
  reg sat_b_next;
  reg [`CSF_IRQ_W-1:0] irq_stat_reg; // sticky event bits
  reg [`CSF_IRQ_W-1:0] irq_stat_next;
  reg [`CSF_IRQ_W-1:0] irq_mask_reg; // event enables
  reg [`CSF_IRQ_W-1:0] irq_mask_next;
  reg [31:0] rdata_next;

  // ==========================================================
  // bus decode
  wire bus_req; // request pending on the bus
  wire bus_wr; // write takes effect this edge
  wire bus_rd_phase; // first cycle of a request: latch read data
  wire [`CSF_IRQ_W-1:0] events; // hardware events this cycle
  wire [WIDTH-1:0] status_now; // status word as currently held
  wire sel_status;
  wire sel_core;
  wire sel_int1;
  wire sel_istat;
  wire sel_imask;
  wire sel_prio;

  assign bus_req = i_avs_read || i_avs_write;
  assign bus_wr = i_avs_write && !o_avs_waitrequest;
  assign bus_rd_phase = bus_req && o_avs_waitrequest;
  assign sel_status = (i_avs_address == `CSF_OFS_STATUS);
  assign sel_core = (i_avs_address == `CSF_OFS_CORE_CTRL);
  assign sel_int1 = (i_avs_address == `CSF_OFS_INT_CTRL1);
  assign sel_istat = (i_avs_address == `CSF_OFS_IRQ_STAT);
  assign sel_imask = (i_avs_address == `CSF_OFS_IRQ_MASK);
  assign sel_prio = (i_avs_address == `CSF_OFS_EFF_PRIO);

  // events: overflow or carry raised by alu, saturation, loop end
  assign events[`CSF_IRQ_OVF] = i_alu_valid && i_upd_ovf && calc_ovf;
  assign events[`CSF_IRQ_C] = i_alu_valid && i_upd_c && calc_c;
  assign events[`CSF_IRQ_SAT] = i_sat_a_set || i_sat_b_set;
  assign events[`CSF_IRQ_RPT] = rpt_reg && !i_repeat_active;

  // status word assembly; combined saturation reads as either set
  function [WIDTH-1:0] pack_status;
    input [2:0] f_lvl;
    input f_rpt;
    input f_n;
    input f_ovf;
    input f_z;
    input f_c;
    input f_sat_a;
    input f_sat_b;
    begin
      pack_status = {WIDTH{1'b0}};
      pack_status[`CSF_B_PRIO_HI:`CSF_B_PRIO_LO] = f_lvl;
      pack_status[`CSF_B_RPT] = f_rpt;
      pack_status[`CSF_B_N] = f_n;
      pack_status[`CSF_B_OVF] = f_ovf;
      pack_status[`CSF_B_Z] = f_z;
      pack_status[`CSF_B_C] = f_c;
      pack_status[`CSF_B_SAT_A] = f_sat_a;
      pack_status[`CSF_B_SAT_B] = f_sat_b;
      pack_status[`CSF_B_SAT_ANY] = f_sat_a | f_sat_b;
    end
  endfunction

  assign status_now = pack_status(lvl_reg, rpt_reg, n_reg, ovf_reg, z_reg, c_reg, sat_a_reg,
                                  sat_b_reg);

  // ==========================================================
  // next-state logic: software writes first, hardware last wins
  always @*
  begin
    lvl_next = lvl_reg;
    lvl_msb_next = lvl_msb_reg;
    nest_dis_next = nest_dis_reg;
    n_next = n_reg;
    ovf_next = ovf_reg;
    z_next = z_reg;
    c_next = c_reg;
    sat_a_next = sat_a_reg;
    sat_b_next = sat_b_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    // software write to the status word
    if (bus_wr && sel_status)
    begin
      if (i_avs_byteenable[0])
      begin
        // priority field locked while nesting is disabled
        if (!nest_dis_reg)
        begin
          lvl_next = i_avs_writedata[`CSF_B_PRIO_HI:`CSF_B_PRIO_LO];
        end
        n_next = i_avs_writedata[`CSF_B_N];
        ovf_next = i_avs_writedata[`CSF_B_OVF];
        z_next = i_avs_writedata[`CSF_B_Z];
        c_next = i_avs_writedata[`CSF_B_C];
      end
      if (i_avs_byteenable[1])
      begin
        // direct write, or a zero in the combined bit clears both
        if (!i_avs_writedata[`CSF_B_SAT_ANY])
        begin
          sat_a_next = 1'b0;
          sat_b_next = 1'b0;
        end
        else
        begin
          sat_a_next = i_avs_writedata[`CSF_B_SAT_A];
          sat_b_next = i_avs_writedata[`CSF_B_SAT_B];
        end
      end
    end
    // core control: priority msb
    else if (bus_wr && sel_core)
    begin
      if (i_avs_byteenable[0])
      begin
        lvl_msb_next = i_avs_writedata[`CSF_B_PRIO_MSB];
      end
    end
    // interrupt control one: nesting disable
    else if (bus_wr && sel_int1)
    begin
      if (i_avs_byteenable[1])
      begin
        nest_dis_next = i_avs_writedata[`CSF_B_NEST_DIS];
      end
    end
    // interrupt mask
    else if (bus_wr && sel_imask)
    begin
      if (i_avs_byteenable[0])
      begin
        irq_mask_next = i_avs_writedata[`CSF_IRQ_W-1:0];
      end
    end
    // interrupt status: write one to clear
    else if (bus_wr && sel_istat)
    begin
      if (i_avs_byteenable[0])
      begin
        irq_stat_next = irq_stat_reg & ~i_avs_writedata[`CSF_IRQ_W-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    irq_stat_next = irq_stat_next | events;
    // interrupt logic loads the full four-bit level
    if (i_prio_load)
    begin
      lvl_next = i_prio_value[2:0];
      lvl_msb_next = i_prio_value[3];
    end
    // alu flags, each only when its update is enabled
    if (i_alu_valid)
    begin
      if (i_upd_n)
      begin
        n_next = calc_n;
      end
      if (i_upd_ovf)
      begin
        ovf_next = calc_ovf;
      end
      if (i_upd_z)
      begin
        // sticky form never sets, only clears on non-zero
        if (!calc_z)
        begin
          z_next = 1'b0;
        end
        else if (!i_z_sticky)
        begin
          z_next = 1'b1;
        end
      end
      if (i_upd_c)
      begin
        c_next = calc_c;
      end
    end
    // accumulator hardware sets saturation over a software clear (write race)
    if (i_sat_a_set)
    begin
      sat_a_next = 1'b1;
    end
    if (i_sat_b_set)
    begin
      sat_b_next = 1'b1;
    end
  end

  // ==========================================================
  // read data mux, latched on the first cycle of a read
  always @*
  begin
    rdata_next = 32'h0000_0000;
    if (sel_status)
    begin
      rdata_next[WIDTH-1:0] = status_now;
    end
    else if (sel_core)
    begin
      rdata_next[`CSF_B_PRIO_MSB] = lvl_msb_reg;
    end
    else if (sel_int1)
    begin
      rdata_next[`CSF_B_NEST_DIS] = nest_dis_reg;
    end
    else if (sel_istat)
    begin
      rdata_next[`CSF_IRQ_W-1:0] = irq_stat_reg;
    end
    else if (sel_imask)
    begin
      rdata_next[`CSF_IRQ_W-1:0] = irq_mask_reg;
    end
    else if (sel_prio)
    begin
      rdata_next[3:0] = {lvl_msb_reg, lvl_reg};
      rdata_next[`CSF_B_BLOCKED] = lvl_msb_reg || (lvl_reg == `CSF_PRIO_TOP);
    end
  end

  // ==========================================================
  // state and output flip-flops
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      lvl_reg <= `CSF_PRIO_RST;
      lvl_msb_reg <= 1'b0;
      nest_dis_reg <= 1'b0;
      rpt_reg <= 1'b0;
      n_reg <= 1'b0;
      ovf_reg <= 1'b0;
      z_reg <= 1'b0;
      c_reg <= 1'b0;
      sat_a_reg <= 1'b0;
      sat_b_reg <= 1'b0;
      irq_stat_reg <= `CSF_IRQ_RST;
      irq_mask_reg <= `CSF_IRQ_RST;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      o_alu_result <= {WIDTH{1'b0}};
      o_status_word <= {WIDTH{1'b0}};
      o_eff_priority <= 4'h0;
      o_user_irq_blocked <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      lvl_reg <= lvl_next;
      lvl_msb_reg <= lvl_msb_next;
      nest_dis_reg <= nest_dis_next;
      rpt_reg <= i_repeat_active;
      n_reg <= n_next;
      ovf_reg <= ovf_next;
      z_reg <= z_next;
      c_reg <= c_next;
      sat_a_reg <= sat_a_next;
      sat_b_reg <= sat_b_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      // one wait cycle, then the answer; released for the next cycle
      o_avs_waitrequest <= !bus_rd_phase;
      if (bus_rd_phase && i_avs_read)
      begin
        o_avs_readdata <= rdata_next;
      end
      if (i_alu_valid)
      begin
        o_alu_result <= calc_result;
      end
      // outputs track the new state in the same edge
      o_status_word <= pack_status(lvl_next, i_repeat_active, n_next, ovf_next,
                                   z_next, c_next, sat_a_next, sat_b_next);
      o_eff_priority <= {lvl_msb_next, lvl_next};
      o_user_irq_blocked <= lvl_msb_next || (lvl_next == `CSF_PRIO_TOP);
      o_irq <= |(irq_stat_next & irq_mask_next);
    end
  end
endmodule // csf_status_core

/* File: tb/csf_status_core_monitor.sv */
// checker for the cpu status flag low byte
`timescale 1ns/1ps
module csf_status_core_monitor #(
  parameter WIDTH = 16,
  parameter ADDR_W = 8
) (
  // clock, reset and bus
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  // alu and core inputs
  input wire logic i_alu_valid,
  input wire logic [WIDTH-1:0] i_alu_a,
  input wire logic [WIDTH-1:0] i_alu_b,
  input wire logic i_alu_sub,
  input wire logic i_upd_n,
  input wire logic i_upd_ovf,
  input wire logic i_upd_z,
  input wire logic i_upd_c,
  input wire logic i_repeat_active,
  input wire logic i_prio_load,
  input wire logic [3:0] i_prio_value,
  // core outputs
  input wire logic [WIDTH-1:0] o_alu_result,
  input wire logic [WIDTH-1:0] o_status_word,
  input wire logic [3:0] o_eff_priority,
  input wire logic o_user_irq_blocked
);
  // ==========================================================
  // reference adder, b inverted for subtract
  wire [WIDTH-1:0] bx = i_alu_b ^ {WIDTH{i_alu_sub}};
  wire [WIDTH:0] sum = {1'b0, i_alu_a} + {1'b0, bx} + {{WIDTH{1'b0}}, i_alu_sub};
  wire ovf = (i_alu_a[WIDTH-1] == bx[WIDTH-1]) && (sum[WIDTH-1] != i_alu_a[WIDTH-1]);
  wire bus_wr = i_avs_write && !o_avs_waitrequest;
  reg nest_dis_reg;
  // tracks the nesting disable bit as written over the bus
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      nest_dis_reg <= 1'b0;
    else if (bus_wr && i_avs_address == 8'h08 && i_avs_byteenable[1])
      nest_dis_reg <= i_avs_writedata[15];
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // properties
  AST_PRIO_FIELD:
    assert property (o_eff_priority[2:0] == o_status_word[7:5]) else $error("level mismatch");
  AST_BLOCKED:
    assert property (o_user_irq_blocked == (o_eff_priority[3] || o_eff_priority[2:0] == 3'h7))
    else $error("blocked wrong");
  AST_PRIO_LOAD:
    assert property (i_prio_load |=> o_eff_priority == $past(i_prio_value)) else $error("load");
  AST_PRIO_LOCK:
    assert property (nest_dis_reg && !i_prio_load |=> $stable(o_status_word[7:5]))
    else $error("level changed while locked");
  AST_RPT_SET:
    assert property ($rose(i_repeat_active) |-> ##[1:2] o_status_word[4])
    else $error("repeat flag not set");
  AST_RPT_CLR:
    assert property ($fell(i_repeat_active) |-> ##[1:2] !o_status_word[4])
    else $error("repeat flag not cleared");
  AST_NEG:
    assert property (i_alu_valid && i_upd_n |=> o_status_word[3] == o_alu_result[WIDTH-1])
    else $error("negative wrong");
  AST_OVF:
    assert property (i_alu_valid && i_upd_ovf |=> o_status_word[2] == $past(ovf))
    else $error("overflow wrong");
  AST_ZERO:
    assert property (i_alu_valid && i_upd_z |=> o_alu_result == '0 || !o_status_word[1])
    else $error("zero not cleared");
  AST_CARRY:
    assert property (i_alu_valid && i_upd_c |=> o_status_word[0] == $past(sum[WIDTH]))
    else $error("carry wrong");
  AST_KEEP:
    assert property (!(i_alu_valid && i_upd_c) && !bus_wr |=> $stable(o_status_word[0]))
    else $error("carry moved");
endmodule // csf_status_core_monitor
bind csf_status_core csf_status_core_monitor #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
  .i_alu_valid(i_alu_valid), .i_alu_a(i_alu_a), .i_alu_b(i_alu_b), .i_alu_sub(i_alu_sub),
  .i_upd_n(i_upd_n), .i_upd_ovf(i_upd_ovf), .i_upd_z(i_upd_z), .i_upd_c(i_upd_c),
  .i_repeat_active(i_repeat_active), .i_prio_load(i_prio_load),
  .i_prio_value(i_prio_value),
  .o_alu_result(o_alu_result), .o_status_word(o_status_word),
  .o_eff_priority(o_eff_priority), .o_user_irq_blocked(o_user_irq_blocked));

/* File: tb/csf_status_core_tb.sv */
// self-checking bench for the cpu status flag low byte
`timescale 1ns/1ps
module csf_status_core_tb;
  // ==========================================================
  // stimulus and observed signals
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] adr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [3:0] be = 4'h0;
  reg av = 1'b0, sub = 1'b0, zs = 1'b0, rpt = 1'b0, sat_a = 1'b0, sbs = 1'b0, il = 1'b0;
  reg [3:0] upd = 4'h0;
  reg [3:0] iv = 4'h0;
  reg [15:0] a = 16'h0, b = 16'h0;
  wire [31:0] rdat;
  wire wrq, blk, irq;
  wire [15:0] res, sw;
  wire [3:0] ep;
  integer mismatches = 0;
  integer comparisons = 0;
  always #5 clk = ~clk;
  csf_status_core uut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wrq), .i_alu_valid(av), .i_alu_a(a),
    .i_alu_b(b), .i_alu_sub(sub), .i_upd_n(upd[3]), .i_upd_ovf(upd[2]), .i_upd_z(upd[1]),
    .i_upd_c(upd[0]), .i_z_sticky(zs), .i_repeat_active(rpt), .i_sat_a_set(sat_a),
    .i_sat_b_set(sbs), .i_prio_load(il), .i_prio_value(iv), .o_alu_result(res),
    .o_status_word(sw), .o_eff_priority(ep), .o_user_irq_blocked(blk), .o_irq(irq));
  // ==========================================================
  // shared tasks
  task finish_test;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task acc(input w, input [7:0] ad, input [31:0] d, input [3:0] bl, output [31:0] q);
    integer n;
  begin
    @(posedge clk);
    adr <= ad; wd <= d; be <= bl; wr <= w; rd <= !w;
    n = 0;
    @(posedge clk);
    #1;
    // look at waitrequest once it has settled after each edge
    while (wrq !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    // the next edge samples waitrequest low: the access completes there
    @(posedge clk);
    q = rdat;
    if (n == 20) mismatches = mismatches + 1;
    wr <= 1'b0; rd <= 1'b0;
    #1;
  end
  endtask
  task wreg(input [7:0] ad, input [31:0] d, input [3:0] bl);
    reg [31:0] q;
  begin
    acc(1'b1, ad, d, bl, q);
  end
  endtask
  task rchk(input string nm, input [7:0] ad, input [31:0] e);
    reg [31:0] q;
  begin
    acc(1'b0, ad, 32'h0, 4'hf, q);
    chk(nm, q, e);
  end
  endtask
  task alu(input [15:0] x, input [15:0] y, input s, input [3:0] u, input z);
  begin
    @(posedge clk);
    a <= x; b <= y; sub <= s; upd <= u; zs <= z; av <= 1'b1;
    @(posedge clk);
    av <= 1'b0;
    #1;
  end
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
  begin
    rchk("status", 8'h00, 32'h0);
    rchk("unmapped", 8'h1c, 32'h0);
  end
  endtask
  task t_alu;
    reg [32:0] tv [0:3];
    reg [16:0] r;
    reg [15:0] bb;
    reg [3:0] e;
    integer i;
  begin
    tv[0] = {16'h7fff, 16'h0001, 1'b0};
    tv[1] = {16'hffff, 16'h0001, 1'b0};
    tv[2] = {16'h0005, 16'h0005, 1'b1};
    tv[3] = {16'h0003, 16'h0005, 1'b1};
    for (i = 0; i < 4; i = i + 1)
    begin
      bb = tv[i][16:1] ^ {16{tv[i][0]}};
      r = {1'b0, tv[i][32:17]} + {1'b0, bb} + {16'h0, tv[i][0]};
      e = {r[15], tv[i][32] == bb[15] && r[15] != tv[i][32], r[15:0] == 16'h0, r[16]};
      alu(tv[i][32:17], tv[i][16:1], tv[i][0], 4'hf, 1'b0);
      chk("result", res, r[15:0]);
      chk("flags", sw[3:0], e);
    end
    alu(16'h8000, 16'h8000, 1'b0, 4'h0, 1'b0);
    chk("unchanged", sw[3:0], e);
    alu(16'h0000, 16'h0000, 1'b0, 4'h2, 1'b1);
    chk("zero sticky", sw[3:0], e);
  end
  endtask
  task t_irq;
  begin
    rchk("irq status", 8'h0c, 32'h3);
    chk("irq masked", irq, 1'b0);
    wreg(8'h10, 32'h1, 4'hf);
    repeat (2) @(posedge clk);
    chk("irq on", irq, 1'b1);
    rchk("irq mask", 8'h10, 32'h1);
    wreg(8'h0c, 32'h1, 4'hf);
    repeat (2) @(posedge clk);
    chk("irq off", irq, 1'b0);
    rchk("irq left", 8'h0c, 32'h2);
  end
  endtask
  task t_repeat;
  begin
    @(posedge clk);
    rpt <= 1'b1;
    repeat (3) @(posedge clk);
    chk("repeat on", sw[4], 1'b1);
    rpt <= 1'b0;
    repeat (3) @(posedge clk);
    chk("repeat off", sw[4], 1'b0);
    rchk("irq ended", 8'h0c, 32'ha);
  end
  endtask
  task t_prio;
  begin
    wreg(8'h00, 32'he0, 4'h1);
    chk("level 7", ep, 4'h7);
    chk("blocked 7", blk, 1'b1);
    wreg(8'h00, 32'h60, 4'h1);
    chk("level 3", ep, 4'h3);
    chk("open 3", blk, 1'b0);
    wreg(8'h04, 32'h08, 4'h1);
    rchk("effective", 8'h14, 32'h1b);
    wreg(8'h04, 32'h0, 4'h1);
    wreg(8'h08, 32'h8000, 4'h2);
    wreg(8'h00, 32'ha0, 4'h1);
    chk("locked", sw[7:5], 3'h3);
    @(posedge clk);
    il <= 1'b1;
    iv <= 4'h5;
    @(posedge clk);
    il <= 1'b0;
    #1;
    chk("loaded", ep, 4'h5);
    wreg(8'h08, 32'h0, 4'h2);
    wreg(8'h00, 32'h40, 4'h1);
    chk("unlocked", sw[7:5], 3'h2);
  end
  endtask
  task t_sat;
  begin
    @(posedge clk);
    sat_a <= 1'b1;
    sbs <= 1'b1;
    @(posedge clk);
    sat_a <= 1'b0;
    sbs <= 1'b0;
    #1;
    chk("sat set", sw[11:10], 2'b11);
    // saturation changed by status writes with only byte one enabled: a zero in bit 8 clears both, else bits 11:10 load
    wreg(8'h00, 32'h0, 4'h2);
    chk("sat clear", sw[11:10], 2'b00);
    wreg(8'h00, 32'h500, 4'h2);
    chk("sat direct", sw[11:10], 2'b01);
    rchk("status sat", 8'h00, 32'h540);
  end
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_alu;
    t_irq;
    t_repeat;
    t_prio;
    t_sat;
    finish_test;
  end
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule // csf_status_core_tb
